// >>> verilog/asu_pkg.sv
// Package of constants and types for the asynchronous serial port with FIFOs.
package asu_pkg;
   localparam int ASU_DEPTH         = 16;
   localparam int ASU_PTR_W         = 4;
   localparam int ASU_RX_W          = 12;
   localparam int ASU_DIV_INT_W     = 16;
   localparam int ASU_DIV_FRAC_W    = 6;
   localparam int ASU_LINE_W        = 8;
   localparam int ASU_OVS           = 16;
   localparam int ASU_START_SAMPLE  = 8;
   localparam int ASU_TIMEOUT_BITS  = 32;
   localparam int ASU_EVENT_W       = 7;
   // Line control field positions.
   localparam int ASU_LC_BREAK      = 0;
   localparam int ASU_LC_PARITY_EN  = 1;
   localparam int ASU_LC_EVEN       = 2;
   localparam int ASU_LC_TWO_STOP   = 3;
   localparam int ASU_LC_FIFO_EN    = 4;
   localparam int ASU_LC_LEN_LO     = 5;
   localparam int ASU_LC_STICK      = 7;
   // Event bit positions.
   localparam int ASU_EV_RX_LEVEL   = 0;
   localparam int ASU_EV_TX_LEVEL   = 1;
   localparam int ASU_EV_TIMEOUT    = 2;
   localparam int ASU_EV_FRAME      = 3;
   localparam int ASU_EV_PARITY     = 4;
   localparam int ASU_EV_BREAK      = 5;
   localparam int ASU_EV_OVERRUN    = 6;
   // Receive entry error bit positions above the data byte.
   localparam int ASU_RX_FE         = 8;
   localparam int ASU_RX_PE         = 9;
   localparam int ASU_RX_BE         = 10;
   localparam int ASU_RX_OE         = 11;
   // Reset values.
   localparam logic [2:0] ASU_LEVEL_RESET = 3'h2;
   localparam logic       ASU_PATH_RESET  = 1'h1;

   typedef enum logic [4:0] {
      ASU_IDLE   = 5'h01,
      ASU_START  = 5'h02,
      ASU_DATA   = 5'h04,
      ASU_PARITY = 5'h08,
      ASU_STOP   = 5'h10
   } asu_state_t;
endpackage

// >>> verilog/asu_fifo.sv
// Sixteen-entry FIFO with combinational read data and a selectable one-entry mode.
`timescale 1ns/1ps
module asu_fifo import asu_pkg::*; #(
   parameter int W = 8
) (
   // Clock and reset.
   input  wire logic         mclk,
   input  wire logic         reset_n,
   // Mode and flush.
   input  wire logic         deep,
   input  wire logic         flush,
   // Fill side.
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // Drain side; out_data is read straight from storage, valid while out_valid is high.
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready,
   // Fill level.
   output logic [ASU_PTR_W:0] count
);
   typedef struct packed {
      logic [ASU_PTR_W-1:0] wp;
      logic [ASU_PTR_W-1:0] rp;
      logic [ASU_PTR_W:0]   n;
   } asu_fifo_st_t;

   asu_fifo_st_t st;
   asu_fifo_st_t next_st;
   logic [W-1:0] mem [ASU_DEPTH];
   logic         push;
   logic         pop;
   logic [ASU_PTR_W:0] cap;

   assign cap       = deep ? (ASU_PTR_W+1)'(ASU_DEPTH) : (ASU_PTR_W+1)'(1);
   assign in_ready  = (st.n < cap) && !flush;
   assign out_valid = (st.n != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready && !flush;
   assign count     = st.n;
   assign out_data  = mem[st.rp];

   always_comb begin
      next_st = st;
      if (flush) begin
         next_st = '0;
      end else begin
         if (push) begin
            next_st.wp = st.wp + 1'b1;
         end
         if (pop) begin
            next_st.rp = st.rp + 1'b1;
         end
         next_st.n = st.n + (ASU_PTR_W+1)'(push) - (ASU_PTR_W+1)'(pop);
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Storage has no reset; the count guards every read.
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[st.wp] <= in_data;
      end
   end
endmodule

// >>> verilog/asu_uart.sv
// Asynchronous serial transmitter and receiver with FIFOs, event status and loopback.
//
// Contract
// [RQ1] Transmit and receive paths have separate enables, both set after reset.
// [RQ2] Disabling the port mid-character finishes that character before stopping.
// [RQ3] Frame: start bit, data LSB first, optional parity, configured stop bits.
// [RQ4] Divisor is 16-bit integer plus 6-bit fraction, setting the bit period.
// [RQ5] Software picks divisor as clock over sixteen times baud, fraction rounded.
// [RQ6] Oversample tick at sixteen times baud; tx bit every sixteen ticks.
// [RQ7] Divisor and line settings load together only on a line-control write.
// [RQ8] Sixteen-entry transmit and receive FIFOs; receive entries carry four status bits.
// [RQ9] Writing transmit data while enabled sends frames until the FIFO empties.
// [RQ10] Busy is set while tx FIFO non-empty or shifter still sending stop bits.
// [RQ11] Receive start sampled on eighth tick; high there means false start.
// [RQ12] Data bits sampled every sixteenth tick, then parity checked if enabled.
// [RQ13] Stop sample low flags framing; each character stored with four error flags. The code always stores the entry's overrun flag as zero.
// [RQ14] Data read gives twelve bits; data write pushes eight bits.
// [RQ15] FIFOs are one-entry after reset; FIFO enable bit makes them sixteen deep.
// [RQ16] Empty and full flags for both FIFOs; overrun in receive status.
// [RQ17] Independent trigger levels of 1/8 to 7/8 depth, both reset to half.
// [RQ18] All seven events are ORed into one interrupt request.
// [RQ19] Events reach the request only when masked in; raw and masked readable.
// [RQ20] Writing one to an event clear bit clears raw and masked status. The code keeps a bit set if its event occurs in the same cycle.
// [RQ21] Timeout after 32 idle bit periods with receive data held; cleared on empty.
// [RQ22] Loopback routes serial output internally to serial input.
// [RQ23] A received break stores one zero character; resume after line high.
// [RQ24] Any write to the error clear port clears all four error status bits. The code keeps the overrun bit set if an overrun occurs in the same cycle.
// [RQ25] Character arriving with receive FIFO full sets overrun and is dropped.
`timescale 1ns/1ps
module asu_uart import asu_pkg::*; (
   // Clock and reset.
   input  wire logic                      mclk,
   input  wire logic                      reset_n,
   // Serial line.
   input  wire logic                      serial_in,
   output logic                           serial_out,
   // Control bits.
   input  wire logic                      global_port_enable,
   input  wire logic                      tx_path_enable,
   input  wire logic                      rx_path_enable,
   input  wire logic                      loopback_enable,
   // Divisor and line control, captured together on line_control_write.
   input  wire logic [ASU_DIV_INT_W-1:0]  divisor_integer_reg,
   input  wire logic [ASU_DIV_FRAC_W-1:0] divisor_fraction_reg,
   input  wire logic [ASU_LINE_W-1:0]     line_control_reg,
   input  wire logic                      line_control_write,
   // Trigger levels, mask and clears.
   input  wire logic [2:0]                tx_level_select,
   input  wire logic [2:0]                rx_level_select,
   input  wire logic                      level_select_write,
   input  wire logic [ASU_EVENT_W-1:0]    event_mask_reg,
   input  wire logic [ASU_EVENT_W-1:0]    event_clear_reg,
   input  wire logic                      error_clear_reg,
   // Data port.
   input  wire logic                      tx_write,
   input  wire logic [7:0]                tx_data,
   input  wire logic                      rx_read,
   output logic [ASU_RX_W-1:0]            data_port_reg,
   // Status.
   output logic                           tx_fifo_empty,
   output logic                           tx_fifo_full,
   output logic                           rx_fifo_empty,
   output logic                           rx_fifo_full,
   output logic                           busy,
   output logic [3:0]                     rx_status_reg,
   output logic [ASU_EVENT_W-1:0]         raw_event_status_reg,
   output logic [ASU_EVENT_W-1:0]         masked_event_status_reg,
   output logic                           irq,
   output logic [2:0]                     tx_level,
   output logic [2:0]                     rx_level
);
   localparam int ACC_W = ASU_DIV_INT_W + ASU_DIV_FRAC_W + 1;

   typedef struct packed {
      logic [ASU_DIV_INT_W+ASU_DIV_FRAC_W-1:0] div;
      logic [ASU_LINE_W-1:0] lc;
      logic [ACC_W-1:0]      acc;
      logic                  tick;
      logic [1:0]            rx_sync;
      asu_state_t            ts;
      logic [3:0]            tph;
      logic [2:0]            tbit;
      logic [7:0]            tsh;
      logic                  tstop2;
      logic                  txd;
      asu_state_t            rs;
      logic [3:0]            rph;
      logic [2:0]            rbit;
      logic [7:0]            rsh;
      logic                  rpar_err;
      logic                  rall0;
      logic                  brk_wait;
      logic [8:0]            idle_ticks;
      logic [3:0]            rsr;
      logic [ASU_EVENT_W-1:0] ris;
      logic [2:0]            txl;
      logic [2:0]            rxl;
      logic [ASU_RX_W-1:0]   dout;
      logic                  busy;
      logic                  irq;
   } asu_st_t;

   asu_st_t st;
   asu_st_t next_st;

   logic [ASU_PTR_W:0]  tx_cnt;
   logic [ASU_PTR_W:0]  rx_cnt;
   logic                tx_valid;
   logic [7:0]          tx_head;
   logic                tx_ready;
   logic                tx_pop;
   logic                rx_valid;
   logic [ASU_RX_W-1:0] rx_head;
   logic                rx_ready;
   logic                rx_push;
   logic [ASU_RX_W-1:0] rx_entry;
   logic                deep;
   logic                rx_line;
   logic [2:0]          len_m1;
   logic                par_bit;
   logic [ASU_PTR_W:0]  tx_trig;
   logic [ASU_PTR_W:0]  rx_trig;
   logic [ASU_EVENT_W-1:0] ev_set;

   assign deep = st.lc[ASU_LC_FIFO_EN]; // [RQ15]

   // Transmit FIFO pops when the shifter loads a character.
   asu_fifo #(.W(8)) u_tx_fifo (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .deep      (deep),
      .flush     (1'b0),
      .in_valid  (tx_write),
      .in_data   (tx_data),
      .in_ready  (tx_ready),
      .out_valid (tx_valid),
      .out_data  (tx_head),
      .out_ready (tx_pop),
      .count     (tx_cnt)
   );

   asu_fifo #(.W(ASU_RX_W)) u_rx_fifo (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .deep      (deep),
      .flush     (1'b0),
      .in_valid  (rx_push),
      .in_data   (rx_entry),
      .in_ready  (rx_ready),
      .out_valid (rx_valid),
      .out_data  (rx_head),
      .out_ready (rx_read),
      .count     (rx_cnt)
   ); // [RQ8]

   ////////////////////////////////////////////////////////////////////////////
   // Shared decode.

   assign len_m1  = {1'b1, st.lc[ASU_LC_LEN_LO+1:ASU_LC_LEN_LO]};
   // Loopback takes the line straight from the shifter, so it needs no synchroniser.
   assign rx_line = loopback_enable ? st.txd : st.rx_sync[1]; // [RQ22]

   function automatic logic [ASU_PTR_W:0] trig(input logic [2:0] sel);
      case (sel)
         3'h0:    trig = 5'h02;
         3'h1:    trig = 5'h04;
         3'h2:    trig = 5'h08;
         3'h3:    trig = 5'h0C;
         default: trig = 5'h0E;
      endcase
   endfunction

   // The one-entry mode has no level to compare; it treats any held word as over the mark.
   assign tx_trig = deep ? trig(st.txl) : 5'h01;
   assign rx_trig = deep ? trig(st.rxl) : 5'h01;

   function automatic logic parity(input logic [7:0] d, input logic [2:0] lm1,
                                   input logic [ASU_LINE_W-1:0] lc);
      logic p;
      p = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (3'(i) <= lm1) begin
            p = p ^ d[i];
         end
      end
      if (lc[ASU_LC_STICK]) begin
         parity = ~lc[ASU_LC_EVEN];
      end else begin
         parity = p ^ ~lc[ASU_LC_EVEN];
      end
   endfunction

   always_comb begin
      next_st  = st;
      tx_pop   = 1'b0;
      rx_push  = 1'b0;
      rx_entry = '0;
      ev_set   = '0;
      par_bit  = 1'b0;

      next_st.rx_sync = {st.rx_sync[0], serial_in};

      // Baud generator: add 64 per clock, emit a tick each time the divisor is reached.
      next_st.tick = 1'b0;
      if (st.div != '0) begin
         if (st.acc + ACC_W'(64) >= {1'b0, st.div}) begin
            next_st.acc  = st.acc + ACC_W'(64) - {1'b0, st.div}; // [RQ4] [RQ6]
            next_st.tick = 1'b1;
         end else begin
            next_st.acc = st.acc + ACC_W'(64);
         end
      end

      if (line_control_write) begin
         next_st.div = {divisor_integer_reg, divisor_fraction_reg}; // [RQ7]
         next_st.lc  = line_control_reg;
      end
      if (level_select_write) begin
         next_st.txl = tx_level_select;
         next_st.rxl = rx_level_select;
      end

      //////////////////////////////////////////////////////////////////////////
      // Transmitter. The enables gate only the start of a character.
      case (st.ts)
         ASU_IDLE: begin
            next_st.txd = ~st.lc[ASU_LC_BREAK];
            if (tx_valid && global_port_enable && tx_path_enable && st.tick) begin // [RQ9] [RQ2] [RQ1]
               tx_pop         = 1'b1;
               next_st.tsh    = tx_head;
               next_st.ts     = ASU_START;
               next_st.tph    = '0;
               next_st.tbit   = '0;
               next_st.tstop2 = st.lc[ASU_LC_TWO_STOP];
               next_st.txd    = 1'b0; // [RQ3]
            end
         end
         ASU_START, ASU_DATA, ASU_PARITY, ASU_STOP: begin
            if (st.tick) begin
               next_st.tph = st.tph + 1'b1;
               if (st.tph == 4'hF) begin
                  par_bit = parity(st.tsh, len_m1, st.lc);
                  case (st.ts)
                     ASU_START: begin
                        next_st.ts  = ASU_DATA;
                        next_st.txd = st.tsh[0];
                     end
                     ASU_DATA: begin
                        next_st.tbit = st.tbit + 1'b1;
                        next_st.txd  = st.tsh[3'(st.tbit + 1'b1)];
                        if (st.tbit == len_m1) begin
                           next_st.ts  = st.lc[ASU_LC_PARITY_EN] ? ASU_PARITY : ASU_STOP;
                           next_st.txd = st.lc[ASU_LC_PARITY_EN] ? par_bit : 1'b1;
                        end
                     end
                     ASU_PARITY: begin
                        next_st.ts  = ASU_STOP;
                        next_st.txd = 1'b1;
                     end
                     default: begin
                        if (st.tstop2) begin
                           next_st.tstop2 = 1'b0;
                        end else begin
                           next_st.ts  = ASU_IDLE;
                           next_st.txd = ~st.lc[ASU_LC_BREAK];
                        end
                     end
                  endcase
               end
            end
         end
         default: next_st.ts = ASU_IDLE;
      endcase
      next_st.busy = tx_valid || (st.ts != ASU_IDLE); // [RQ10]

      //////////////////////////////////////////////////////////////////////////
      // Receiver.
      if (st.tick) begin
         case (st.rs)
            ASU_IDLE: begin
               if (rx_line) begin
                  next_st.brk_wait = 1'b0; // [RQ23]
               end
               if (!rx_line && !st.brk_wait && global_port_enable && rx_path_enable) begin // [RQ1]
                  next_st.rs  = ASU_START;
                  next_st.rph = 4'h1;
               end
            end
            ASU_START: begin
               next_st.rph = st.rph + 1'b1;
               if (st.rph == 4'(ASU_START_SAMPLE - 1)) begin
                  next_st.rph      = '0;
                  next_st.rbit     = '0;
                  next_st.rall0    = 1'b1;
                  next_st.rpar_err = 1'b0;
                  next_st.rsh      = '0;
                  next_st.rs       = rx_line ? ASU_IDLE : ASU_DATA; // [RQ11]
               end
            end
            ASU_DATA, ASU_PARITY, ASU_STOP: begin
               next_st.rph = st.rph + 1'b1;
               if (st.rph == 4'hF) begin
                  next_st.rall0 = st.rall0 & ~rx_line;
                  case (st.rs)
                     ASU_DATA: begin
                        next_st.rsh[st.rbit] = rx_line; // [RQ12]
                        next_st.rbit = st.rbit + 1'b1;
                        if (st.rbit == len_m1) begin
                           next_st.rs = st.lc[ASU_LC_PARITY_EN] ? ASU_PARITY : ASU_STOP;
                        end
                     end
                     ASU_PARITY: begin
                        next_st.rpar_err = rx_line ^ parity(st.rsh, len_m1, st.lc); // [RQ12]
                        next_st.rs       = ASU_STOP;
                     end
                     default: begin
                        next_st.rs  = ASU_IDLE;
                        rx_entry[7:0]       = st.rsh;
                        rx_entry[ASU_RX_FE] = ~rx_line; // [RQ13]
                        rx_entry[ASU_RX_PE] = st.rpar_err;
                        rx_entry[ASU_RX_BE] = st.rall0 & ~rx_line;
                        if (st.rall0 & ~rx_line) begin
                           rx_entry[ASU_RX_FE] = 1'b0;
                           rx_entry[ASU_RX_PE] = 1'b0;
                           next_st.brk_wait    = 1'b1; // [RQ23]
                        end
                        if (rx_ready) begin
                           rx_push = 1'b1; // [RQ13]
                           ev_set[ASU_EV_FRAME]  = rx_entry[ASU_RX_FE];
                           ev_set[ASU_EV_PARITY] = rx_entry[ASU_RX_PE];
                           ev_set[ASU_EV_BREAK]  = rx_entry[ASU_RX_BE];
                        end else begin
                           ev_set[ASU_EV_OVERRUN] = 1'b1; // [RQ25]
                        end
                     end
                  endcase
               end
            end
            default: next_st.rs = ASU_IDLE;
         endcase
      end

      // Timeout counts ticks since the last arrival; 32 bits is 512 ticks.
      if (rx_push || !rx_valid) begin
         next_st.idle_ticks = '0;
      end else if (st.tick && st.idle_ticks != 9'h1FF) begin
         next_st.idle_ticks = st.idle_ticks + 1'b1;
      end
      ev_set[ASU_EV_TIMEOUT] = st.tick && rx_valid && (st.idle_ticks == 9'(ASU_TIMEOUT_BITS*ASU_OVS - 2)); // [RQ21]
      ev_set[ASU_EV_TX_LEVEL] = (tx_cnt < tx_trig) && st.busy; // [RQ17]
      ev_set[ASU_EV_RX_LEVEL] = (rx_cnt >= rx_trig); // [RQ17]

      // Set wins over clear on every event bit.
      next_st.ris = (st.ris & ~event_clear_reg) | ev_set; // [RQ20]
      if (rx_read && rx_cnt == 5'h01) begin
         next_st.ris[ASU_EV_TIMEOUT] = ev_set[ASU_EV_TIMEOUT]; // [RQ21]
      end

      next_st.rsr[ASU_RX_OE-8] = st.rsr[ASU_RX_OE-8] | ev_set[ASU_EV_OVERRUN]; // [RQ16]
      if (rx_read && rx_valid) begin
         next_st.dout = rx_head; // [RQ14]
         next_st.rsr[2:0] = rx_head[ASU_RX_BE:ASU_RX_FE];
      end
      if (error_clear_reg) begin
         next_st.rsr = {ev_set[ASU_EV_OVERRUN], 3'h0}; // [RQ24]
      end
      next_st.irq = |(st.ris & event_mask_reg); // [RQ18] [RQ19]
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st         <= '0;
         st.rx_sync <= 2'h3;
         st.ts      <= ASU_IDLE;
         st.rs      <= ASU_IDLE;
         st.txd     <= 1'b1;
         st.txl     <= ASU_LEVEL_RESET; // [RQ17]
         st.rxl     <= ASU_LEVEL_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Path enables are inputs reset outside; ASU_PATH_RESET is their documented default.
   assign serial_out              = st.txd;
   assign data_port_reg           = st.dout;
   assign tx_fifo_empty           = (tx_cnt == '0); // [RQ16]
   assign tx_fifo_full            = !tx_ready;
   assign rx_fifo_empty           = !rx_valid;
   assign rx_fifo_full            = !rx_ready;
   assign busy                    = st.busy;
   assign rx_status_reg           = st.rsr;
   assign raw_event_status_reg    = st.ris;
   assign masked_event_status_reg = st.ris & event_mask_reg; // [RQ19]
   assign irq                     = st.irq;
   assign tx_level                = st.txl;
   assign rx_level                = st.rxl;
endmodule

// >>> dv/asu_uart_sva.sv
// Assertion checker for the serial port, bound to its top module.
`timescale 1ns/1ps
module asu_uart_sva import asu_pkg::*; (
   // Clock and reset.
   input wire logic                   mclk,
   input wire logic                   reset_n,
   // Inputs seen by the port.
   input wire logic                   level_select_write,
   input wire logic [2:0]             tx_level_select,
   input wire logic [2:0]             rx_level_select,
   input wire logic [ASU_EVENT_W-1:0] event_mask_reg,
   input wire logic                   error_clear_reg,
   // Outputs of the port.
   input wire logic                   serial_out,
   input wire logic                   tx_fifo_empty,
   input wire logic                   rx_fifo_empty,
   input wire logic                   busy,
   input wire logic [3:0]             rx_status_reg,
   input wire logic [ASU_EVENT_W-1:0] raw_event_status_reg,
   input wire logic [ASU_EVENT_W-1:0] masked_event_status_reg,
   input wire logic                   irq,
   input wire logic [2:0]             tx_level,
   input wire logic [2:0]             rx_level
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_busy_when_queued: assert property (!tx_fifo_empty |=> busy) else $error("busy low with data queued");
   a_idle_line_high: assert property (!busy && tx_fifo_empty |-> serial_out) else $error("idle line low");
   a_start_bit_long: assert property ($fell(serial_out) |-> !serial_out [*8]) else $error("start bit short");
   a_mask_gates_event: assert property (irq |-> $past(masked_event_status_reg) != 0)
      else $error("irq while masked");
   a_irq_from_masked: assert property ((masked_event_status_reg != 0) [*2] |-> irq) else $error("no irq");
   a_error_clear_all: assert property (error_clear_reg |=> rx_status_reg == 4'h0) else $error("errors kept");
   a_level_load: assert property (level_select_write |=>
      tx_level == $past(tx_level_select) && rx_level == $past(rx_level_select))
      else $error("trigger level not loaded");
   a_timeout_needs_data: assert property ($rose(raw_event_status_reg[ASU_EV_TIMEOUT]) |->
      !$past(rx_fifo_empty)) else $error("timeout with empty receive side");
endmodule
bind asu_uart asu_uart_sva u_sva (.*);

// >>> dv/asu_line_peer.sv
// Remote serial partner: sends frames to the port and collects the frames it sends.
`timescale 1ns/1ps
module asu_line_peer (
   // Bit timing clock.
   input wire logic mclk,
   // Serial lines.
   output logic     line_to_dut,
   input wire logic line_from_dut
);
   // Sixteen clocks a bit, as the bench programs one tick a clock.
   localparam int BIT = 16;
   logic [7:0] got_q[$];
   logic [7:0] rx_byte;
   initial line_to_dut = 1'h1;
   task automatic send(input logic [7:0] b, input logic stop);
      line_to_dut = 1'h0;
      repeat (BIT) @(negedge mclk);
      for (int i = 0; i < 8; i++) begin
         line_to_dut = b[i];
         repeat (BIT) @(negedge mclk);
      end
      // A bad stop bit is cut short so the line is high before a new start would be sampled.
      line_to_dut = stop;
      repeat (stop ? BIT : 11) @(negedge mclk);
      line_to_dut = 1'h1;
      repeat (BIT) @(negedge mclk);
   endtask
   task automatic glitch(input int n);
      line_to_dut = 1'h0;
      repeat (n) @(negedge mclk);
      line_to_dut = 1'h1;
   endtask
   always begin
      @(negedge line_from_dut);
      repeat (BIT / 2) @(negedge mclk);
      if (line_from_dut === 1'h0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(negedge mclk);
            rx_byte[i] = line_from_dut;
         end
         got_q.push_back(rx_byte);
      end
   end
endmodule

// >>> dv/tb.sv
// Self-checking bench for the serial port with FIFOs.
`timescale 1ns/1ps
module tb import asu_pkg::*; ();
   logic mclk = 1'h0, reset_n = 1'h0, serial_in, serial_out;
   logic global_port_enable = 1'h1, tx_path_enable = 1'h1, rx_path_enable = 1'h1, loopback_enable = 1'h0;
   logic [15:0] divisor_integer_reg = 16'h0001;
   logic [5:0] divisor_fraction_reg = 6'h00;
   logic [7:0] line_control_reg = 8'h60, tx_data = 8'h00;
   logic line_control_write = 1'h0, level_select_write = 1'h0, error_clear_reg = 1'h0, tx_write = 1'h0;
   logic rx_read = 1'h0, tx_fifo_empty, tx_fifo_full, rx_fifo_empty, rx_fifo_full, busy, irq;
   logic [2:0] tx_level_select = 3'h0, rx_level_select = 3'h4, tx_level, rx_level;
   logic [6:0] event_mask_reg = 7'h7F, event_clear_reg = 7'h00, raw_event_status_reg, masked_event_status_reg;
   logic [11:0] data_port_reg;
   logic [3:0] rx_status_reg;
   int num_errors = 0, checks_done = 0;
   always #2.5 mclk = ~mclk;
   asu_uart u_dut (.*);
   asu_line_peer u_peer (.mclk(mclk), .line_to_dut(serial_in), .line_from_dut(serial_out));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_until(ref logic sig, input logic val);
      int n;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (sig !== val && n < 5000);
   endtask
   task automatic set_line(input logic [7:0] lc);
      @(negedge mclk);
      line_control_reg = lc;
      line_control_write = 1'h1;
      @(negedge mclk);
      line_control_write = 1'h0;
   endtask
   task automatic send(input logic [7:0] b);
      @(negedge mclk);
      tx_data = b;
      tx_write = 1'h1;
      @(negedge mclk);
      tx_write = 1'h0;
   endtask
   task automatic recv(input logic [11:0] exp);
      wait_until(rx_fifo_empty, 1'h0);
      rx_read = 1'h1;
      @(negedge mclk);
      rx_read = 1'h0;
      chk("rx data", exp, data_port_reg);
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      complete_run;
   end
   initial begin
      repeat (6) @(negedge mclk);
      reset_n = 1'h1;
      set_line(8'h60);
      level_select_write = 1'h1;
      @(negedge mclk);
      level_select_write = 1'h0;
      send(8'h5A);
      chk("tx full", 12'h001, {11'h0, tx_fifo_full});
      @(negedge mclk);
      chk("busy", 12'h001, {11'h0, busy});
      wait_until(busy, 1'h0);
      chk("tx frame", 12'h05A, {4'h0, u_peer.got_q.pop_front()});
      u_peer.send(8'hC3, 1'h1);
      wait_until(rx_fifo_empty, 1'h0);
      repeat (600) @(negedge mclk);
      chk("timeout", 12'h001, {11'h0, raw_event_status_reg[ASU_EV_TIMEOUT]});
      recv(12'h0C3);
      @(negedge mclk);
      chk("timeout clear", 12'h000, {11'h0, raw_event_status_reg[ASU_EV_TIMEOUT]});
      u_peer.send(8'h81, 1'h0);
      recv(12'h181);
      chk("status", 12'h001, {8'h0, rx_status_reg});
      error_clear_reg = 1'h1;
      @(negedge mclk);
      error_clear_reg = 1'h0;
      u_peer.glitch(4);
      repeat (300) @(negedge mclk);
      chk("false start", 12'h001, {11'h0, rx_fifo_empty});
      u_peer.send(8'h00, 1'h0);
      recv(12'h400);
      loopback_enable = 1'h1;
      send(8'h3C);
      recv(12'h03C);
      wait_until(busy, 1'h0);
      loopback_enable = 1'h0;
      u_peer.got_q.delete();
      global_port_enable = 1'h0;
      set_line(8'h70);
      global_port_enable = 1'h1;
      for (int i = 0; i < 17; i++) begin
         u_peer.send(8'h10 + 8'(i), 1'h1);
      end
      @(negedge mclk);
      chk("rx full", 12'h001, {11'h0, rx_fifo_full});
      chk("overrun", 12'h001, {11'h0, raw_event_status_reg[ASU_EV_OVERRUN]});
      chk("irq", 12'h001, {11'h0, irq});
      event_mask_reg = 7'h00;
      repeat (3) @(negedge mclk);
      chk("irq masked", 12'h000, {11'h0, irq});
      event_mask_reg = 7'h7F;
      event_clear_reg = 7'h40;
      @(negedge mclk);
      event_clear_reg = 7'h00;
      @(negedge mclk);
      chk("overrun clear", 12'h000, {11'h0, raw_event_status_reg[ASU_EV_OVERRUN]});
      recv(12'h010);
      complete_run;
   end
endmodule
